/* File: inc/ipq_pkg.sv */
// constants for the instruction prefetch queue
// assumes one system clock shared by cpu and instruction memories
// Function
// - the queue fetches words ahead of the pipeline, and a fetch past valid memory may return an invalid opcode.
// - when running from ram blocks the queue holds at most 8 sixteen-bit words ahead.
// - when running from flash the queue holds at most 16 sixteen-bit words ahead.
// - a flash fetch past the last valid flash word is flagged as an uncorrectable ecc error.
// - a fetch crossing into an immediately following valid block returns correct words with no fault.
package ipq_pkg;
    localparam int unsigned ADDR_W      = 22;
    localparam int unsigned DATA_W      = 16;
    localparam int unsigned PTR_W       = 4;
    localparam int unsigned CNT_W       = 5;
    localparam logic [CNT_W-1:0] RAM_DEPTH   = 5'h08;
    localparam logic [CNT_W-1:0] FLASH_DEPTH = 5'h10;
    // address windows of the instruction memories
    localparam logic [ADDR_W-1:0] DED_RAM_FIRST_LO  = 22'h000000;
    localparam logic [ADDR_W-1:0] DED_RAM_SECOND_HI = 22'h0007ff;
    localparam logic [ADDR_W-1:0] SHARED_RAM_LO     = 22'h00c000;
    localparam logic [ADDR_W-1:0] SHARED_RAM_HI     = 22'h013fff;
    localparam logic [ADDR_W-1:0] FLASH_LO          = 22'h080000;
    localparam logic [ADDR_W-1:0] FLASH_HI          = 22'h09ffff;
    localparam logic [DATA_W-1:0] INVALID_OPCODE    = 16'h0000;
    typedef enum logic [1:0] {
        IPQ_SRC_NONE  = 2'h0,
        IPQ_SRC_RAM   = 2'h1,
        IPQ_SRC_FLASH = 2'h3
    } ipq_src_t;
endpackage

/* File: design/ipq_region.sv */
// classifies a fetch address into ram, flash or unmapped
// assumes contiguous ram blocks are one window, so a block joint never faults
`timescale 1ns/1ps
module ipq_region (
    // address
    input  wire logic [ipq_pkg::ADDR_W-1:0] addr_in,
    // class
    output ipq_pkg::ipq_src_t               src_out
);
    always_comb begin
        if (addr_in <= ipq_pkg::DED_RAM_SECOND_HI) begin
            src_out = ipq_pkg::IPQ_SRC_RAM;
        end else if (addr_in >= ipq_pkg::SHARED_RAM_LO && addr_in <= ipq_pkg::SHARED_RAM_HI) begin
            src_out = ipq_pkg::IPQ_SRC_RAM;
        end else if (addr_in >= ipq_pkg::FLASH_LO && addr_in <= ipq_pkg::FLASH_HI) begin
            src_out = ipq_pkg::IPQ_SRC_FLASH;
        end else begin
            src_out = ipq_pkg::IPQ_SRC_NONE;
        end
    end
endmodule

/* File: design/ipq_queue.sv */
// prefetch queue between cpu decode and instruction memories
// assumes memory answers mem_ack_in one or more cycles after a request, in order,
// one request outstanding at a time
`timescale 1ns/1ps
module ipq_queue (
    // clock and reset
    input  wire logic                       ref_clk_in,
    input  wire logic                       rst_in,
    // cpu side
    input  wire logic                       redirect_in,
    input  wire logic [ipq_pkg::ADDR_W-1:0] redirect_addr_in,
    input  wire logic                       take_in,
    output logic                            word_valid_out,
    output logic [ipq_pkg::DATA_W-1:0]      word_out,
    output logic                            word_invalid_out,
    output logic                            ecc_uncorr_out,
    // memory side
    output logic                            mem_req_out,
    output logic [ipq_pkg::ADDR_W-1:0]      mem_addr_out,
    input  wire logic                       mem_ack_in,
    input  wire logic [ipq_pkg::DATA_W-1:0] mem_data_in
);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [ipq_pkg::CNT_W-1:0] depth_of(input ipq_pkg::ipq_src_t s);
        depth_of = (s == ipq_pkg::IPQ_SRC_FLASH) ? ipq_pkg::FLASH_DEPTH : ipq_pkg::RAM_DEPTH;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic [ipq_pkg::DATA_W-1:0] mem_r [0:15];
    logic [ipq_pkg::DATA_W-1:0] mem_nxt [0:15];
    logic                       bad_r [0:15];
    logic                       bad_nxt [0:15];
    logic [ipq_pkg::PTR_W-1:0]  wr_r, wr_nxt, rd_r, rd_nxt;
    logic [ipq_pkg::CNT_W-1:0]  cnt_r, cnt_nxt;
    logic [ipq_pkg::ADDR_W-1:0] fetch_r, fetch_nxt;
    logic                       busy_r, busy_nxt;
    logic                       drop_r, drop_nxt;
    ipq_pkg::ipq_src_t          exec_src_r, exec_src_nxt;
    logic                       ovalid_r, ovalid_nxt;
    logic [ipq_pkg::DATA_W-1:0] oword_r, oword_nxt;
    logic                       oinv_r, oinv_nxt;
    logic                       ecc_r, ecc_nxt;
    logic                       req_r, req_nxt;
    logic [ipq_pkg::ADDR_W-1:0] maddr_r, maddr_nxt;
    ipq_pkg::ipq_src_t          fsrc;
    ipq_pkg::ipq_src_t          rsrc;
    logic                       pop;
    logic                       fill;

    ipq_region u_fetch_region (
        .addr_in (fetch_r),
        .src_out (fsrc)
    );
    ipq_region u_redir_region (
        .addr_in (redirect_addr_in),
        .src_out (rsrc)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            mem_nxt[i] = mem_r[i];
            bad_nxt[i] = bad_r[i];
        end
        wr_nxt       = wr_r;
        rd_nxt       = rd_r;
        cnt_nxt      = cnt_r;
        fetch_nxt    = fetch_r;
        busy_nxt     = busy_r;
        drop_nxt     = drop_r;
        exec_src_nxt = exec_src_r;
        ovalid_nxt   = ovalid_r;
        oword_nxt    = oword_r;
        oinv_nxt     = oinv_r;
        ecc_nxt      = 1'b0;
        req_nxt      = 1'b0;
        maddr_nxt    = maddr_r;
        pop          = take_in && ovalid_r;
        fill         = mem_ack_in && busy_r && !drop_r;
        if (mem_ack_in && busy_r) begin
            busy_nxt = 1'b0;
            drop_nxt = 1'b0;
        end
        if (redirect_in) begin
            // discard everything, an in-flight answer is dropped on arrival
            wr_nxt       = '0;
            rd_nxt       = '0;
            cnt_nxt      = '0;
            ovalid_nxt   = 1'b0;
            fetch_nxt    = redirect_addr_in;
            exec_src_nxt = rsrc;
            if (busy_r && !mem_ack_in) begin
                drop_nxt = 1'b1;
            end
        end else begin
            if (fill) begin
                mem_nxt[wr_r] = mem_data_in;
                // past valid memory the word is flagged, never trusted
                bad_nxt[wr_r] = (fsrc == ipq_pkg::IPQ_SRC_NONE);
                wr_nxt        = wr_r + 4'h1;
                fetch_nxt     = fetch_r + 22'h000001;
                if (fsrc == ipq_pkg::IPQ_SRC_NONE && exec_src_r == ipq_pkg::IPQ_SRC_FLASH) begin
                    ecc_nxt = 1'b1;
                end
            end
            if ((pop || !ovalid_r) && (cnt_r != '0)) begin
                ovalid_nxt = 1'b1;
                oword_nxt  = bad_r[rd_r] ? ipq_pkg::INVALID_OPCODE : mem_r[rd_r];
                oinv_nxt   = bad_r[rd_r];
                rd_nxt     = rd_r + 4'h1;
            end else if (pop) begin
                ovalid_nxt = 1'b0;
            end
            cnt_nxt = cnt_r + {4'h0, fill} - {4'h0, ((pop || !ovalid_r) && (cnt_r != '0))};
            // limit counts queue, output word and in-flight so depth never overflows
            if (!busy_nxt && !drop_nxt && ((cnt_nxt + {4'h0, ovalid_nxt}) < depth_of(exec_src_r))) begin
                req_nxt   = 1'b1;
                busy_nxt  = 1'b1;
                maddr_nxt = fill ? fetch_r + 22'h000001 : fetch_r;
            end
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < 16; i++) begin
                mem_r[i] <= '0;
                bad_r[i] <= 1'b0;
            end
            wr_r       <= '0;
            rd_r       <= '0;
            cnt_r      <= '0;
            fetch_r    <= ipq_pkg::DED_RAM_FIRST_LO;
            busy_r     <= 1'b0;
            drop_r     <= 1'b0;
            exec_src_r <= ipq_pkg::IPQ_SRC_RAM;
            ovalid_r   <= 1'b0;
            oword_r    <= '0;
            oinv_r     <= 1'b0;
            ecc_r      <= 1'b0;
            req_r      <= 1'b0;
            maddr_r    <= '0;
        end else begin
            for (int i = 0; i < 16; i++) begin
                mem_r[i] <= mem_nxt[i];
                bad_r[i] <= bad_nxt[i];
            end
            wr_r       <= wr_nxt;
            rd_r       <= rd_nxt;
            cnt_r      <= cnt_nxt;
            fetch_r    <= fetch_nxt;
            busy_r     <= busy_nxt;
            drop_r     <= drop_nxt;
            exec_src_r <= exec_src_nxt;
            ovalid_r   <= ovalid_nxt;
            oword_r    <= oword_nxt;
            oinv_r     <= oinv_nxt;
            ecc_r      <= ecc_nxt;
            req_r      <= req_nxt;
            maddr_r    <= maddr_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign word_valid_out   = ovalid_r;
    assign word_out         = oword_r;
    assign word_invalid_out = oinv_r;
    assign ecc_uncorr_out   = ecc_r;
    assign mem_req_out      = req_r;
    assign mem_addr_out     = maddr_r;
endmodule

/* File: sim/ipq_queue_properties.sv */
// port assertions for the prefetch queue
// assumes one clock and an async active-high reset
`timescale 1ns/1ps
module ipq_queue_props (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // cpu side
    input wire logic redirect_in,
    input wire logic [ipq_pkg::ADDR_W-1:0] redirect_addr_in,
    input wire logic take_in,
    input wire logic word_valid_out,
    input wire logic [ipq_pkg::DATA_W-1:0] word_out,
    input wire logic word_invalid_out,
    input wire logic ecc_uncorr_out,
    // memory side
    input wire logic mem_req_out,
    input wire logic [ipq_pkg::ADDR_W-1:0] mem_addr_out,
    input wire logic mem_ack_in,
    input wire logic [ipq_pkg::DATA_W-1:0] mem_data_in
);
    default clocking @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);
    ////////////////////////////////////////////////////////////
    a_first_req: assert property ($fell(rst_in) |-> ##[0:1] mem_req_out)
        else $error("no fetch after reset");
    a_req_pulse: assert property (mem_req_out && !redirect_in |=> !mem_req_out)
        else $error("fetch request too long");
    a_addr_held: assert property (!mem_req_out |-> $stable(mem_addr_out))
        else $error("fetch address moved");
    a_word_holds: assert property (word_valid_out && !take_in && !redirect_in
        |=> word_valid_out && $stable(word_out) && $stable(word_invalid_out)) else $error("word lost");
    a_invalid_zero: assert property (word_valid_out && word_invalid_out |-> word_out == 16'h0)
        else $error("invalid word not zero");
    a_ecc_pulse: assert property (ecc_uncorr_out |=> !ecc_uncorr_out)
        else $error("ecc flag too long");
    a_ecc_addr: assert property (ecc_uncorr_out |-> mem_addr_out > ipq_pkg::FLASH_HI)
        else $error("ecc inside flash");
    a_redirect_flush: assert property (redirect_in |=> !word_valid_out [*2])
        else $error("stale word after redirect");
    a_redirect_fetch: assert property (redirect_in |-> ##[1:8] mem_req_out)
        else $error("no fetch after redirect");
endmodule
bind ipq_queue ipq_queue_props u_props (.*);

/* File: sim/ipq_mem_model.sv */
// ram and flash model behind the queue
// assumes one request outstanding; lat_in adds wait states
`timescale 1ns/1ps
module ipq_mem_model (
    input  wire logic                       ref_clk_in,
    input  wire logic                       rst_in,
    input  wire logic                       mem_req_in,
    input  wire logic [ipq_pkg::ADDR_W-1:0] mem_addr_in,
    input  wire logic [1:0]                 lat_in,
    output logic                            mem_ack_out,
    output logic [ipq_pkg::DATA_W-1:0]      mem_data_out
);
    logic [ipq_pkg::ADDR_W-1:0] addr_r;
    logic [1:0]                 wait_r;
    logic                       busy_r;
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            busy_r <= 1'b0;
            mem_ack_out <= 1'b0;
            mem_data_out <= 16'h0;
        end else begin
            mem_ack_out <= 1'b0;
            // released bus toggles so a stale word never matches
            mem_data_out <= ~mem_data_out;
            if (mem_req_in) begin
                busy_r <= 1'b1;
                wait_r <= lat_in;
                addr_r <= mem_addr_in;
            end else if (busy_r && wait_r != 2'h0) begin
                wait_r <= wait_r - 2'h1;
            end else if (busy_r) begin
                busy_r <= 1'b0;
                mem_ack_out <= 1'b1;
                mem_data_out <= addr_r[15:0] ^ 16'ha5c3;
            end
        end
    end
endmodule

/* File: sim/instruction_prefetch_queue_tb.sv */
// self-checking bench for the prefetch queue
// assumes the memory model answers requests in order
`timescale 1ns/1ps
module instruction_prefetch_queue_tb;
    logic ref_clk_in = 0, rst_in = 1, redirect_in = 0, take_in = 0, ack, wv, winv, ecc, req;
    logic [ipq_pkg::ADDR_W-1:0] redirect_addr_in = '0, maddr;
    logic [15:0] word, mdata;
    logic [1:0] lat = 2'h0;
    int fail_count = 0, checked = 0, reqs = 0, eccs = 0, seed = 19;
    always #2.5 ref_clk_in = ~ref_clk_in;
    ipq_queue dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .redirect_in(redirect_in),
        .redirect_addr_in(redirect_addr_in), .take_in(take_in), .word_valid_out(wv), .word_out(word),
        .word_invalid_out(winv), .ecc_uncorr_out(ecc), .mem_req_out(req), .mem_addr_out(maddr),
        .mem_ack_in(ack), .mem_data_in(mdata));
    ipq_mem_model mem (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .mem_req_in(req), .mem_addr_in(maddr),
        .lat_in(lat), .mem_ack_out(ack), .mem_data_out(mdata));
    always @(negedge ref_clk_in) begin
        reqs += int'(req);
        eccs += int'(ecc);
    end
    ////////////////////////////////////////////////////////////
    task automatic chk(logic [16:0] seen, logic [16:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d failures %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // redirect, stall while the queue fills, then take n words
    task automatic run(logic [21:0] a, int n, logic rnd);
        logic [21:0] e;
        logic ok;
        e = a;
        @(posedge ref_clk_in) #1;
        redirect_in = 1'b1;
        redirect_addr_in = a;
        @(posedge ref_clk_in) #1;
        redirect_in = 1'b0;
        reqs = 0;
        eccs = 0;
        repeat (120) begin
            lat = 2'($random(seed));
            @(posedge ref_clk_in) #1;
        end
        chk(17'(reqs), (a >= ipq_pkg::FLASH_LO) ? 17'h10 : 17'h8);
        chk({16'h0, eccs != 0}, {16'h0, a >= ipq_pkg::FLASH_LO && a + 22'h10 > ipq_pkg::FLASH_HI});
        for (int k = 0; k < 400 && n > 0; k++) begin
            take_in = rnd ? 1'($random(seed)) : 1'b1;
            lat = 2'($random(seed));
            @(negedge ref_clk_in);
            if (wv === 1'b1 && take_in) begin
                ok = e <= ipq_pkg::DED_RAM_SECOND_HI || (e >= ipq_pkg::SHARED_RAM_LO && e <= ipq_pkg::SHARED_RAM_HI)
                    || (e >= ipq_pkg::FLASH_LO && e <= ipq_pkg::FLASH_HI);
                chk({winv, word}, {!ok, ok ? e[15:0] ^ 16'ha5c3 : 16'h0});
                e++;
                n--;
            end
            @(posedge ref_clk_in) #1;
        end
        take_in = 1'b0;
        chk(17'(n), 17'h0);
    endtask
    initial begin
        repeat (3) @(posedge ref_clk_in);
        #1 rst_in = 1'b0;
        run(22'h0003f8, 16, 1'b0);
        run(22'h0007f8, 12, 1'b1);
        run(22'h013ff8, 12, 1'b1);
        run(22'h09fff8, 12, 1'b0);
        run(22'h080000, 5, 1'b1);
        run(22'h00c000, 5, 1'b1);
        end_sim;
    end
    initial begin
        #100000;
        fail_count++;
        end_sim;
    end
endmodule
